/* hw/pci_edge.v */
// per-pin rising and falling edge detectors with their own enables
`timescale 1ns/1ps
`include "pci_map.vh"

module pci_edge (
  input  wire                 clk_i,
  input  wire                 rstn_i,
  input  wire [`PCI_NPIN-1:0] pin_i,
  input  wire [`PCI_NPIN-1:0] rise_en_i,
  input  wire [`PCI_NPIN-1:0] fall_en_i,
  output wire [`PCI_NPIN-1:0] edge_o
);

  reg  [`PCI_NPIN-1:0] prev;
  reg  [2:0]           primed;

  // no edge is reported against the reset value of prev: the two sync stages
  // and prev must all hold real pin samples first, which takes three edges
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev   <= `PCI_VEC_RST;
      primed <= 3'h0;
    end else begin
      prev   <= pin_i;  // see RULE14
      primed <= {primed[1:0], 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PCI_NPIN; g = g + 1) begin : g_det
      wire rise_seen;
      wire fall_seen;
      assign rise_seen = primed[2] & pin_i[g] & ~prev[g] & rise_en_i[g];  // see RULE1 see RULE2
      assign fall_seen = primed[2] & ~pin_i[g] & prev[g] & fall_en_i[g];  // see RULE3
      assign edge_o[g] = rise_seen | fall_seen;  // see RULE4
    end
  endgenerate

endmodule

/* hw/pci_sync.v */
// two-flop synchroniser for the change-capable pin vector
`timescale 1ns/1ps
`include "pci_map.vh"

module pci_sync (
  input  wire                 clk_i,
  input  wire                 rstn_i,
  input  wire [`PCI_NPIN-1:0] pin_i,
  output reg  [`PCI_NPIN-1:0] pin_o
);

  reg [`PCI_NPIN-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta  <= `PCI_VEC_RST;
      pin_o <= `PCI_VEC_RST;
    end else begin
      meta  <= pin_i;
      pin_o <= meta;
    end
  end

endmodule

/* hw/pci_top.v */
// pin change interrupt block: per-pin edge flags, register port and interrupt request
// Function
// RULE1 - each change-capable pin has independent rising and falling edge detectors
// RULE2 - rising edges detected only while the pin's rise enable bit is one
// RULE3 - falling edges detected only while the pin's fall enable bit is one
// RULE4 - both enables set means either polarity is detected
// RULE5 - any pin or combination of pins may be an interrupt source
// RULE6 - interrupt raised only while the master change interrupt enable is set
// RULE7 - master enable clear: flags still set, no interrupt request
// RULE8 - either fuse set removes change detection from the master clear pin
// RULE9 - ports a, b, c and only pin three of port e detect changes
// RULE10 - enabled edge sets the pin's flag and, if enabled, requests interrupt
// RULE11 - read-only summary flag is the or of all pin flags
// RULE12 - edge during a clearing write leaves the flag set
// RULE13 - change wakes the device when enabled; flags valid before wake
// RULE14 - pins synchronised and compared with previous sample, one-cycle edge
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pci_map.vh"

module pci_top (
  input  wire                clk_i,
  input  wire                rstn_i,
  input  wire [5:0]          pin_a_i,
  input  wire [3:0]          pin_b_i,
  input  wire [7:0]          pin_c_i,
  input  wire                pin_e3_i,
  input  wire                reset_pin_enable_fuse_i,
  input  wire                low_voltage_program_fuse_i,
  input  wire [`PCI_AW-1:0]  addr_i,
  input  wire [`PCI_DW-1:0]  wdata_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output reg  [`PCI_DW-1:0]  rdata_o,
  output reg                 irq_o,
  output reg                 wake_o,
  output reg                 change_summary_flag_o
);

  reg  [`PCI_NPIN-1:0] rise_enable_bits;
  reg  [`PCI_NPIN-1:0] fall_enable_bits;
  reg  [`PCI_NPIN-1:0] change_flag_bits;
  reg                  change_irq_enable;
  reg                  master_clear_pin_port_off;

  reg  [`PCI_NPIN-1:0] next_rise;
  reg  [`PCI_NPIN-1:0] next_fall;
  reg  [`PCI_NPIN-1:0] next_flag;
  reg                  next_irq_enable;
  reg  [`PCI_DW-1:0]   next_rdata;

  wire [`PCI_NPIN-1:0] pin_raw;
  wire [`PCI_NPIN-1:0] pin_sync;
  wire [`PCI_NPIN-1:0] edge_evt;
  wire [`PCI_NPIN-1:0] pin_avail;
  wire [`PCI_NPIN-1:0] rise_eff;
  wire [`PCI_NPIN-1:0] fall_eff;
  wire                 next_summary;

  // only implemented pins exist in the vector, so absent pins cannot flag
  assign pin_raw = {pin_e3_i, pin_c_i, pin_b_i, pin_a_i};  // see RULE9

  // fuses are static straps; caught by a clocked flop, never by the reset itself
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      master_clear_pin_port_off <= 1'b1;
    end else begin
      master_clear_pin_port_off <= reset_pin_enable_fuse_i | low_voltage_program_fuse_i;  // see RULE8
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PCI_NPIN; g = g + 1) begin : g_avail
      if (g == `PCI_E3_BIT) begin : g_master_clear_pin
        assign pin_avail[g] = ~master_clear_pin_port_off;  // see RULE8
      end else begin : g_port
        assign pin_avail[g] = 1'b1;
      end
    end
  endgenerate

  // per-pin configuration, gated by availability
  assign rise_eff = rise_enable_bits & pin_avail;  // see RULE5
  assign fall_eff = fall_enable_bits & pin_avail;

  pci_sync u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .pin_i  (pin_raw),
    .pin_o  (pin_sync)
  );

  pci_edge u_edge (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pin_sync),
    .rise_en_i (rise_eff),
    .fall_en_i (fall_eff),
    .edge_o    (edge_evt)
  );

  // register writes
  always @* begin
    next_rise       = rise_enable_bits;
    next_fall       = fall_enable_bits;
    next_flag       = change_flag_bits;
    next_irq_enable = change_irq_enable;
    if (wr_i) begin
      case (addr_i)
        `PCI_ADDR_RISE_A: begin
          next_rise[`PCI_A_LSB +: `PCI_A_W] = wdata_i[`PCI_A_W-1:0];
        end
        `PCI_ADDR_FALL_A: begin
          next_fall[`PCI_A_LSB +: `PCI_A_W] = wdata_i[`PCI_A_W-1:0];
        end
        `PCI_ADDR_FLAG_A: begin
          next_flag[`PCI_A_LSB +: `PCI_A_W] = wdata_i[`PCI_A_W-1:0];
        end
        `PCI_ADDR_RISE_B: begin
          next_rise[`PCI_B_LSB +: `PCI_B_W] = wdata_i[`PCI_DW-1:`PCI_B_POS];
        end
        `PCI_ADDR_FALL_B: begin
          next_fall[`PCI_B_LSB +: `PCI_B_W] = wdata_i[`PCI_DW-1:`PCI_B_POS];
        end
        `PCI_ADDR_FLAG_B: begin
          next_flag[`PCI_B_LSB +: `PCI_B_W] = wdata_i[`PCI_DW-1:`PCI_B_POS];
        end
        `PCI_ADDR_RISE_C: begin
          next_rise[`PCI_C_LSB +: `PCI_C_W] = wdata_i;
        end
        `PCI_ADDR_FALL_C: begin
          next_fall[`PCI_C_LSB +: `PCI_C_W] = wdata_i;
        end
        `PCI_ADDR_FLAG_C: begin
          next_flag[`PCI_C_LSB +: `PCI_C_W] = wdata_i;
        end
        `PCI_ADDR_RISE_E: begin
          next_rise[`PCI_E3_BIT] = wdata_i[`PCI_E_POS];
        end
        `PCI_ADDR_FALL_E: begin
          next_fall[`PCI_E3_BIT] = wdata_i[`PCI_E_POS];
        end
        `PCI_ADDR_FLAG_E: begin
          next_flag[`PCI_E3_BIT] = wdata_i[`PCI_E_POS];
        end
        `PCI_ADDR_IRQ_EN: begin
          next_irq_enable = wdata_i[`PCI_IRQ_BIT];
        end
        `PCI_ADDR_IRQ_CLR: begin
          // write one clears every pin flag at once
          if (wdata_i[`PCI_IRQ_BIT]) begin
            next_flag = `PCI_VEC_RST;
          end
        end
        default: begin
          next_flag = change_flag_bits;
        end
      endcase
    end
    // an edge in the write cycle wins over whatever was written
    next_flag = next_flag | edge_evt;  // see RULE10 see RULE12
  end

  assign next_summary = |next_flag;  // see RULE11

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_enable_bits      <= `PCI_VEC_RST;
      fall_enable_bits      <= `PCI_VEC_RST;
      change_flag_bits      <= `PCI_VEC_RST;
      change_irq_enable     <= 1'b0;
      change_summary_flag_o <= 1'b0;
      irq_o                 <= 1'b0;
      wake_o                <= 1'b0;
    end else begin
      rise_enable_bits      <= next_rise;
      fall_enable_bits      <= next_fall;
      change_flag_bits      <= next_flag;  // see RULE7
      change_irq_enable     <= next_irq_enable;
      change_summary_flag_o <= next_summary;  // see RULE11
      // request and wake appear with the flag or with the enable write, never ahead of the flag
      irq_o                 <= next_summary & next_irq_enable;  // see RULE6 see RULE10
      wake_o                <= next_summary & next_irq_enable;  // see RULE13
    end
  end

  // read data, valid only in the cycle after the read strobe
  always @* begin
    next_rdata = `PCI_BYTE_ZERO;
    if (rd_i) begin
      case (addr_i)
        `PCI_ADDR_RISE_A: begin
          next_rdata[`PCI_A_W-1:0] = rise_enable_bits[`PCI_A_LSB +: `PCI_A_W];
        end
        `PCI_ADDR_FALL_A: begin
          next_rdata[`PCI_A_W-1:0] = fall_enable_bits[`PCI_A_LSB +: `PCI_A_W];
        end
        `PCI_ADDR_FLAG_A: begin
          next_rdata[`PCI_A_W-1:0] = change_flag_bits[`PCI_A_LSB +: `PCI_A_W];
        end
        `PCI_ADDR_RISE_B: begin
          next_rdata[`PCI_DW-1:`PCI_B_POS] = rise_enable_bits[`PCI_B_LSB +: `PCI_B_W];
        end
        `PCI_ADDR_FALL_B: begin
          next_rdata[`PCI_DW-1:`PCI_B_POS] = fall_enable_bits[`PCI_B_LSB +: `PCI_B_W];
        end
        `PCI_ADDR_FLAG_B: begin
          next_rdata[`PCI_DW-1:`PCI_B_POS] = change_flag_bits[`PCI_B_LSB +: `PCI_B_W];
        end
        `PCI_ADDR_RISE_C: begin
          next_rdata = rise_enable_bits[`PCI_C_LSB +: `PCI_C_W];
        end
        `PCI_ADDR_FALL_C: begin
          next_rdata = fall_enable_bits[`PCI_C_LSB +: `PCI_C_W];
        end
        `PCI_ADDR_FLAG_C: begin
          next_rdata = change_flag_bits[`PCI_C_LSB +: `PCI_C_W];
        end
        `PCI_ADDR_RISE_E: begin
          next_rdata[`PCI_E_POS] = rise_enable_bits[`PCI_E3_BIT];
        end
        `PCI_ADDR_FALL_E: begin
          next_rdata[`PCI_E_POS] = fall_enable_bits[`PCI_E3_BIT];
        end
        `PCI_ADDR_FLAG_E: begin
          next_rdata[`PCI_E_POS] = change_flag_bits[`PCI_E3_BIT];
        end
        `PCI_ADDR_IRQ_EN: begin
          next_rdata[`PCI_IRQ_BIT] = change_irq_enable;
        end
        `PCI_ADDR_IRQ_REQ: begin
          next_rdata[`PCI_IRQ_BIT] = change_summary_flag_o;  // see RULE11
        end
        default: begin
          next_rdata = `PCI_BYTE_ZERO;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `PCI_BYTE_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule

/* pkg/pci_map.vh */
// register map, field positions, reset values and pin layout of the pin change block
`ifndef PCI_MAP_VH
`define PCI_MAP_VH

`define PCI_AW              13
`define PCI_DW              8
`define PCI_NPIN            19

// pin vector layout: port a 5:0, port b 7:4, port c 7:0, port e pin three
`define PCI_A_LSB           0
`define PCI_A_W             6
`define PCI_B_LSB           6
`define PCI_B_W             4
`define PCI_C_LSB           10
`define PCI_C_W             8
`define PCI_E3_BIT          18

`define PCI_ADDR_RISE_A     13'h1F3D
`define PCI_ADDR_FALL_A     13'h1F3E
`define PCI_ADDR_FLAG_A     13'h1F3F
`define PCI_ADDR_RISE_B     13'h1F48
`define PCI_ADDR_FALL_B     13'h1F49
`define PCI_ADDR_FLAG_B     13'h1F4A
`define PCI_ADDR_RISE_C     13'h1F53
`define PCI_ADDR_FALL_C     13'h1F54
`define PCI_ADDR_FLAG_C     13'h1F55
`define PCI_ADDR_RISE_E     13'h1F59
`define PCI_ADDR_FALL_E     13'h1F5A
`define PCI_ADDR_FLAG_E     13'h1F5B
`define PCI_ADDR_IRQ_EN     13'h1F60
`define PCI_ADDR_IRQ_REQ    13'h1F61
`define PCI_ADDR_IRQ_CLR    13'h1F62

// port b sits in bits 7:4, port e pin in bit 3
`define PCI_B_POS           4
`define PCI_E_POS           3
`define PCI_IRQ_BIT         0

`define PCI_VEC_RST         19'h00000
`define PCI_BYTE_ZERO       8'h00

`endif

/* tb/pci_assertions.sv */
// port-level assertions for the pin change block
`timescale 1ns/1ps
`include "pci_map.vh"
module pci_checker (
  input wire               clk_i,
  input wire               rstn_i,
  input wire [5:0]         pin_a_i,
  input wire [3:0]         pin_b_i,
  input wire [7:0]         pin_c_i,
  input wire               pin_e3_i,
  input wire [`PCI_AW-1:0] addr_i,
  input wire               wr_i,
  input wire               rd_i,
  input wire [`PCI_DW-1:0] rdata_o,
  input wire               irq_o,
  input wire               wake_o,
  input wire               change_summary_flag_o
);
  wire [18:0] pins = {pin_e3_i, pin_c_i, pin_b_i, pin_a_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wake;
    irq_o == wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  property p_irq_src;
    irq_o |-> change_summary_flag_o;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without flag");
  // a flag is seen three samples after a pin moved, or one after a write
  property p_sum_rise;
    $rose(change_summary_flag_o) |-> $past(wr_i) || ($past(pins, 3) != $past(pins, 4));
  endproperty
  a_sum_rise: assert property (p_sum_rise) else $error("flag without cause");
  property p_sum_fall;
    $fell(change_summary_flag_o) |-> $past(wr_i) || $past(wr_i, 2);
  endproperty
  a_sum_fall: assert property (p_sum_fall) else $error("flag dropped alone");
  property p_irq_rise;
    $rose(irq_o) |-> $rose(change_summary_flag_o) || $past(wr_i) || $past(wr_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
  property p_unused_a;
    rd_i && addr_i == `PCI_ADDR_FLAG_A |=> rdata_o[7:6] == 2'h0;
  endproperty
  a_unused_a: assert property (p_unused_a) else $error("port a bits 7:6 set");
  property p_unused_b;
    rd_i && addr_i == `PCI_ADDR_FLAG_B |=> rdata_o[3:0] == 4'h0;
  endproperty
  a_unused_b: assert property (p_unused_b) else $error("port b bits 3:0 set");
  property p_unused_e;
    rd_i && addr_i == `PCI_ADDR_FLAG_E |=> (rdata_o & 8'hF7) == 8'h00;
  endproperty
  a_unused_e: assert property (p_unused_e) else $error("port e extra bits");
endmodule
bind pci_top pci_checker pci_checker_inst (.clk_i, .rstn_i, .pin_a_i, .pin_b_i, .pin_c_i,
  .pin_e3_i, .addr_i, .wr_i, .rd_i, .rdata_o, .irq_o, .wake_o, .change_summary_flag_o);

/* tb/pci_pin_model.sv */
// external pin sources facing the pin change block
`timescale 1ns/1ps
module pci_pin_model (
  input  wire [18:0] level_i,
  output wire [5:0]  pin_a_o,
  output wire [3:0]  pin_b_o,
  output wire [7:0]  pin_c_o,
  output wire        pin_e3_o
);
  // push-pull sources: levels move only on the bench's command
  assign pin_a_o  = level_i[5:0];
  assign pin_b_o  = level_i[9:6];
  assign pin_c_o  = level_i[17:10];
  assign pin_e3_o = level_i[18];
endmodule

/* tb/tb_top.sv */
// self-checking bench for the pin change block
`timescale 1ns/1ps
`include "pci_map.vh"
module tb_top;
  reg                clk_i = 1'b0;
  reg                rstn_i = 1'b0;
  reg  [18:0]        lvl = 19'h00000;
  reg                fz_rst = 1'b0;
  reg                fz_lvp = 1'b0;
  reg  [`PCI_AW-1:0] addr_i = 13'h0000;
  reg  [`PCI_DW-1:0] wdata_i = 8'h00;
  reg                wr_i = 1'b0;
  reg                rd_i = 1'b0;
  wire [5:0]         pa;
  wire [3:0]         pb;
  wire [7:0]         pc;
  wire               pe;
  wire [7:0]         rdata_o;
  wire               irq_o;
  wire               wake_o;
  wire               sum_o;
  integer            errors = 0;
  integer            checks_done = 0;
  integer            fz;
  initial forever #4 clk_i = ~clk_i;
  pci_pin_model pci_pin_model_inst (.level_i(lvl), .pin_a_o(pa), .pin_b_o(pb),
    .pin_c_o(pc), .pin_e3_o(pe));
  pci_top pci_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .pin_a_i(pa), .pin_b_i(pb),
    .pin_c_i(pc), .pin_e3_i(pe), .reset_pin_enable_fuse_i(fz_rst),
    .low_voltage_program_fuse_i(fz_lvp), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o),
    .change_summary_flag_o(sum_o));
  task chk8(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input got, input exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task wr(input [12:0] a, input [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // data stands one cycle only, so it is taken mid-cycle
  task rd(input [12:0] a, input [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk8(rdata_o, exp);
  endtask
  task pin(input [18:0] v);
    @(posedge clk_i);
    lvl <= v;
    repeat (4) @(posedge clk_i);
  endtask
  task do_reset;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    errors = errors + 1;
    wrap_up;
  end
  initial begin
    do_reset;
    rd(`PCI_ADDR_RISE_A, 8'h00);
    rd(`PCI_ADDR_FLAG_C, 8'h00);
    rd(`PCI_ADDR_IRQ_EN, 8'h00);
    $display("test reset done");
    wr(`PCI_ADDR_RISE_A, 8'h01);
    wr(`PCI_ADDR_FALL_A, 8'h02);
    wr(`PCI_ADDR_RISE_C, 8'h80);
    wr(`PCI_ADDR_FALL_C, 8'h80);
    pin(19'h00003);
    rd(`PCI_ADDR_FLAG_A, 8'h01);
    pin(19'h00000);
    rd(`PCI_ADDR_FLAG_A, 8'h03);
    pin(19'h20000);
    pin(19'h00000);
    rd(`PCI_ADDR_FLAG_C, 8'h80);
    chk1(sum_o, 1'b1);
    chk1(irq_o, 1'b0);
    $display("test polarity done");
    wr(`PCI_ADDR_IRQ_EN, 8'h01);
    rd(`PCI_ADDR_IRQ_REQ, 8'h01);
    chk1(irq_o, 1'b1);
    chk1(wake_o, 1'b1);
    wr(`PCI_ADDR_IRQ_REQ, 8'h00);
    rd(`PCI_ADDR_IRQ_REQ, 8'h01);
    wr(`PCI_ADDR_FLAG_A, 8'h00);
    rd(`PCI_ADDR_FLAG_A, 8'h00);
    chk1(sum_o, 1'b1);
    wr(`PCI_ADDR_FLAG_C, 8'h00);
    rd(`PCI_ADDR_FLAG_C, 8'h00);
    // pin lands two edges ahead so its edge meets the clearing write
    @(posedge clk_i);
    lvl <= 19'h20000;
    @(posedge clk_i);
    wr(`PCI_ADDR_FLAG_C, 8'h00);
    rd(`PCI_ADDR_FLAG_C, 8'h80);
    wr(`PCI_ADDR_IRQ_CLR, 8'h01);
    rd(`PCI_ADDR_IRQ_CLR, 8'h00);
    rd(`PCI_ADDR_FLAG_C, 8'h00);
    chk1(sum_o, 1'b0);
    chk1(irq_o, 1'b0);
    rd(13'h1F40, 8'h00);
    $display("test master and clear done");
    wr(`PCI_ADDR_RISE_B, 8'hF0);
    pin(19'h203C0);
    rd(`PCI_ADDR_FLAG_B, 8'hF0);
    $display("test port b done");
    for (fz = 0; fz < 3; fz = fz + 1) begin
      fz_rst <= (fz == 1);
      fz_lvp <= (fz == 2);
      do_reset;
      wr(`PCI_ADDR_RISE_E, 8'h08);
      wr(`PCI_ADDR_FALL_E, 8'h08);
      pin(lvl ^ 19'h40000);
      rd(`PCI_ADDR_FLAG_E, (fz == 0) ? 8'h08 : 8'h00);
    end
    $display("test port e and fuses done");
    wrap_up;
  end
endmodule
